/* fer_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fer_host (
    // clock
    input  wire logic        clk,
    // requests
    output var  logic        cfg_wr,
    output var  logic        cfg_rd,
    output var  logic [11:0] cfg_addr,
    output var  logic [31:0] cfg_wdata,
    // answer
    input  wire logic [31:0] cfg_rdata
);
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 12'h0;
        cfg_wdata = 32'h0;
    end
    // released lines show the inverse, never a stale copy
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        cfg_addr = ~a;
        cfg_wdata = ~d;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(negedge clk);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        cfg_addr = ~a;
        d = cfg_rdata;
    endtask
endmodule
`default_nettype wire

/* fer_pkg.sv */
// What this block does
// - two-bit fatal policy: 00 report, 01 internal reset, 10 block, 11 block plus link down
// - report policy, external fatal: log header, send fatal message, assert fatal output
// - report policy, ecc failure: send fatal interrupt message, always assert fatal output
// - internal-reset policy, base mode only: any fatal triggers chip reset, no messages
// - block policy: log uncorrectable status, assert fatal output, all ports stop tlps
// - packet partway out when blocking starts is ended with an edb symbol
// - block plus link down: all block actions and force upstream link down
// - once fenced, stay fenced until fundamental reset
// - hot-reset scope bit: 0 all but sticky and specific, 1 config space only
// - hot-reset scope bit survives hot reset; config writes and fundamental-reset eeprom load change it
// - reload-disable bit: 0 reload eeprom on hot reset or dl_down, 1 no reload
// - propagation-disable bit: ignore hot reset, no dl_down reset, no downstream hot reset
// - virtual-interface access bit: 0 retry type 0 config, 1 accept, nt base only
// - virtual-interface access bit resets to 1 without eeprom, 0 with eeprom
// - link-interface access bit: 0 retry type 0 config, 1 accept, nt base only
// - nt-link load inhibit skips nt link eeprom load under three reset conditions
// - nt-link-only load loads only nt link entries under the same conditions
// - in virtual switch mode or downstream port nt bits read zero, writes ignored
package fer_pkg;
    localparam logic [11:0] REG_OFFSET    = 12'ha30;
    localparam int          POLICY_LSB    = 0;
    localparam int          SCOPE_BIT     = 2;
    localparam int          RELOAD_DIS    = 3;
    localparam int          PROP_DIS      = 4;
    localparam int          TEST_BIT      = 5;
    localparam int          VIF_BIT       = 24;
    localparam int          LIF_BIT       = 25;
    localparam int          INHIBIT_BIT   = 26;
    localparam int          ONLY_BIT      = 27;
    localparam logic [31:0] WRITE_MASK_US = 32'h0000_003f;
    localparam logic [31:0] WRITE_MASK_NT = 32'h0f00_0000;
    localparam logic [1:0]  POLICY_RESET  = 2'h0;
    typedef enum logic [1:0] {
        FER_REPORT  = 2'b00,
        FER_IRESET  = 2'b01,
        FER_BLOCK   = 2'b10,
        FER_BLKDOWN = 2'b11
    } fer_policy_t;
endpackage

/* fer_reset_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module fer_reset_ctl (
    // control bits
    input  wire logic scope,
    input  wire logic reload_dis,
    input  wire logic prop_dis,
    input  wire logic nt_inhibit,
    input  wire logic nt_only,
    input  wire logic nt_enabled,
    // reset events
    input  wire logic us_hot_reset,
    input  wire logic us_dl_down,
    input  wire logic ntl_reset,
    // resulting actions
    output logic      hot_reset_full,
    output logic      hot_reset_cfg,
    output logic      downstream_hot_reset,
    output logic      eeprom_reload,
    output logic      eeprom_skip_ntlink,
    output logic      eeprom_ntlink_only
);
    logic us_hot_taken;
    logic dl_reset;
    logic cond_hot;
    logic cond_dl;
    logic cond_ntl;
    logic cond_any;

    assign us_hot_taken = us_hot_reset & ~prop_dis;
    assign dl_reset     = us_dl_down & ~prop_dis;
    assign hot_reset_full = (us_hot_taken & ~scope) | dl_reset;
    assign hot_reset_cfg  = us_hot_taken & scope;
    assign downstream_hot_reset = us_hot_taken | dl_reset;
    assign eeprom_reload = (us_hot_taken | us_dl_down) & ~reload_dis;
    assign cond_hot = us_hot_taken & ~reload_dis & ~scope;
    assign cond_dl  = us_dl_down & ~prop_dis & ~reload_dis & ~scope;
    assign cond_ntl = ntl_reset & ~reload_dis;
    assign cond_any = nt_enabled & (cond_hot | cond_dl | cond_ntl);
    assign eeprom_skip_ntlink = cond_any & nt_inhibit;
    assign eeprom_ntlink_only = cond_any & nt_only & ~nt_inhibit;
endmodule
`default_nettype wire

/* fer_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fer_top #(
    parameter int NUM_VS = 2
) (
    // clock and reset (rst_n is the fundamental reset)
    input  wire logic              clk,
    input  wire logic              rst_n,
    // port configuration
    input  wire logic              is_upstream,
    input  wire logic              base_mode,
    input  wire logic              nt_present,
    input  wire logic              eeprom_present,
    // configuration access
    input  wire logic              cfg_wr,
    input  wire logic              cfg_rd,
    input  wire logic [11:0]       cfg_addr,
    input  wire logic [31:0]       cfg_wdata,
    output logic [31:0]            cfg_rdata,
    // eeprom load at fundamental reset and at hot reset
    input  wire logic              ee_load_valid,
    input  wire logic              ee_load_fundamental,
    input  wire logic [31:0]       ee_load_data,
    // fatal events
    input  wire logic              fatal_external,
    input  wire logic              fatal_ecc,
    input  wire logic [NUM_VS-1:0] fatal_vs_sel,
    // reset events
    input  wire logic              us_hot_reset,
    input  wire logic              us_dl_down,
    input  wire logic              ntl_reset,
    // transmit state
    input  wire logic              tx_in_packet,
    // nt config requests
    input  wire logic              vif_type0_cfg,
    input  wire logic              lif_type0_cfg,
    // fatal actions
    output logic                   fatal_error_out_n,
    output logic [NUM_VS-1:0]      per_vswitch_fatal_error_out_n,
    output logic                   log_header,
    output logic                   send_fatal_msg,
    output logic                   send_fatal_int_msg,
    output logic                   log_uncorr_status,
    output logic                   internal_chip_reset,
    output logic                   tx_block,
    output logic                   tx_insert_edb,
    output logic                   force_link_down,
    // nt access answers
    output logic                   vif_cfg_retry,
    output logic                   lif_cfg_retry,
    // reset actions
    output logic                   hot_reset_full,
    output logic                   hot_reset_cfg,
    output logic                   downstream_hot_reset,
    output logic                   eeprom_reload,
    output logic                   eeprom_skip_ntlink,
    output logic                   eeprom_ntlink_only
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [31:0]       ctl;
    logic              fenced;
    logic              fatal_flag;
    logic [NUM_VS-1:0] vs_flag;
    logic              strap_done;

    logic        hit;
    logic        nt_enabled;
    logic [31:0] wmask;
    logic [31:0] next_ctl;
    logic [31:0] read_view;
    logic [1:0]  policy;
    logic        fatal_any;
    logic        do_block;
    logic        do_report;
    logic        do_ireset;

    assign hit        = cfg_addr == fer_pkg::REG_OFFSET;
    assign nt_enabled = base_mode & nt_present & is_upstream;
    // nt bits only writable in base mode on an upstream port
    assign wmask = is_upstream ?
        (fer_pkg::WRITE_MASK_US | (nt_enabled ? fer_pkg::WRITE_MASK_NT : 32'h0000_0000)) :
        32'h0000_0000;
    // scope bit: config writes allowed, eeprom only at fundamental reset
    always_comb begin
        next_ctl = ctl;
        if (cfg_wr && hit) begin
            next_ctl = (ctl & ~wmask) | (cfg_wdata & wmask);
        end
        if (ee_load_valid && is_upstream) begin
            next_ctl = (ctl & ~wmask) | (ee_load_data & wmask);
            if (!ee_load_fundamental) begin
                next_ctl[fer_pkg::SCOPE_BIT] = ctl[fer_pkg::SCOPE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // sticky control; only the fundamental reset clears it
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl        <= 32'h0000_0000;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            // strap caught after release, not in the reset branch
            ctl <= {7'h00, ~eeprom_present & nt_enabled, 24'h00_0000};
        end else begin
            ctl <= next_ctl;
        end
    end

    // downstream or non-nt view reads zero on masked fields
    assign read_view = ctl & wmask;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (cfg_rd) begin
            cfg_rdata <= hit ? read_view : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // fatal policy
    // ------------------------------------------------------------
    assign policy    = ctl[fer_pkg::POLICY_LSB +: 2];
    assign fatal_any = (fatal_external | fatal_ecc) & strap_done;
    assign do_report = fatal_any & (policy == fer_pkg::FER_REPORT);
    // internal reset is a base-mode feature only
    assign do_ireset = fatal_any & (policy == fer_pkg::FER_IRESET) & base_mode;
    assign do_block  = fatal_any & policy[1];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            log_header          <= 1'b0;
            send_fatal_msg      <= 1'b0;
            send_fatal_int_msg  <= 1'b0;
            log_uncorr_status   <= 1'b0;
            internal_chip_reset <= 1'b0;
        end else begin
            log_header          <= do_report & fatal_external;
            send_fatal_msg      <= do_report & fatal_external;
            send_fatal_int_msg  <= do_report & fatal_ecc;
            log_uncorr_status   <= do_block;
            internal_chip_reset <= do_ireset;
        end
    end

    // fence holds until fundamental reset; no software clear exists
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fenced          <= 1'b0;
            force_link_down <= 1'b0;
        end else begin
            if (do_block) begin
                fenced <= 1'b1;
            end
            if (do_block && policy == fer_pkg::FER_BLKDOWN) begin
                force_link_down <= 1'b1;
            end
        end
    end

    assign tx_block = fenced | do_block;

    // edb fires once, the cycle after fencing first bites mid-packet
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_insert_edb <= 1'b0;
        end else begin
            tx_insert_edb <= do_block & ~fenced & tx_in_packet;
        end
    end

    // ------------------------------------------------------------
    // fatal outputs, active low, held until fundamental reset
    // ------------------------------------------------------------
    logic fatal_assert;
    assign fatal_assert = do_report | do_block;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fatal_flag <= 1'b0;
        end else if (fatal_assert) begin
            fatal_flag <= 1'b1;
        end
    end
    assign fatal_error_out_n = ~fatal_flag;

    genvar g;
    generate
        for (g = 0; g < NUM_VS; g++) begin : gen_vs
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    vs_flag[g] <= 1'b0;
                end else if (fatal_assert && fatal_vs_sel[g]) begin
                    vs_flag[g] <= 1'b1;
                end
            end
            assign per_vswitch_fatal_error_out_n[g] = ~vs_flag[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // nt config access
    // ------------------------------------------------------------
    assign vif_cfg_retry = nt_enabled & vif_type0_cfg & ~ctl[fer_pkg::VIF_BIT];
    assign lif_cfg_retry = nt_enabled & lif_type0_cfg & ~ctl[fer_pkg::LIF_BIT];

    // ------------------------------------------------------------
    // reset scope and eeprom reload decisions
    // ------------------------------------------------------------
    fer_reset_ctl u_reset_ctl (
        .scope                (ctl[fer_pkg::SCOPE_BIT]),
        .reload_dis           (ctl[fer_pkg::RELOAD_DIS]),
        .prop_dis             (ctl[fer_pkg::PROP_DIS]),
        .nt_inhibit           (ctl[fer_pkg::INHIBIT_BIT]),
        .nt_only              (ctl[fer_pkg::ONLY_BIT]),
        .nt_enabled           (nt_enabled),
        .us_hot_reset         (us_hot_reset),
        .us_dl_down           (us_dl_down),
        .ntl_reset            (ntl_reset),
        .hot_reset_full       (hot_reset_full),
        .hot_reset_cfg        (hot_reset_cfg),
        .downstream_hot_reset (downstream_hot_reset),
        .eeprom_reload        (eeprom_reload),
        .eeprom_skip_ntlink   (eeprom_skip_ntlink),
        .eeprom_ntlink_only   (eeprom_ntlink_only)
    );
endmodule
`default_nettype wire

/* fer_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module fer_top_bench;
    localparam logic [11:0] A = fer_pkg::REG_OFFSET;
    localparam logic [8:0]  EXP [4] = '{9'h182, 9'h047, 9'h032, 9'h03a};
    logic clk = 1'b0, rst_n = 1'b0, is_upstream = 1'b1, base_mode = 1'b1, nt_present = 1'b1;
    logic eeprom_present = 1'b1, ee_load_valid = 1'b0, ee_load_fundamental = 1'b0, fatal_external = 1'b0;
    logic fatal_ecc = 1'b0, us_hot_reset = 1'b0, tx_in_packet = 1'b0, vif_type0_cfg = 1'b0, lif_type0_cfg = 1'b0;
    logic us_dl_down = 1'b0, ntl_reset = 1'b0;
    logic [1:0]  fatal_vs_sel = 2'h1;
    logic [31:0] ee_load_data = 32'h0, rv, cfg_rdata, cfg_wdata;
    logic [11:0] cfg_addr;
    logic [1:0]  per_vswitch_fatal_error_out_n;
    logic cfg_wr, cfg_rd, fatal_error_out_n, log_header, send_fatal_msg, send_fatal_int_msg, log_uncorr_status;
    logic internal_chip_reset, tx_block, tx_insert_edb, force_link_down, vif_cfg_retry, lif_cfg_retry;
    logic hot_reset_full, hot_reset_cfg, downstream_hot_reset, eeprom_reload, eeprom_skip_ntlink, eeprom_ntlink_only;
    int num_errors = 0, checked = 0, cyc = 0;
    fer_host u_host (.clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata);
    fer_top #(.NUM_VS(2)) u_fer_top (.clk, .rst_n, .is_upstream, .base_mode, .nt_present, .eeprom_present,
        .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata, .ee_load_valid, .ee_load_fundamental, .ee_load_data,
        .fatal_external, .fatal_ecc, .fatal_vs_sel, .us_hot_reset, .us_dl_down, .ntl_reset,
        .tx_in_packet, .vif_type0_cfg, .lif_type0_cfg, .fatal_error_out_n, .per_vswitch_fatal_error_out_n,
        .log_header, .send_fatal_msg, .send_fatal_int_msg, .log_uncorr_status, .internal_chip_reset, .tx_block,
        .tx_insert_edb, .force_link_down, .vif_cfg_retry, .lif_cfg_retry, .hot_reset_full, .hot_reset_cfg,
        .downstream_hot_reset, .eeprom_reload, .eeprom_skip_ntlink, .eeprom_ntlink_only);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // fundamental reset is the only way out of a fence
    task automatic fres();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
    endtask
    task automatic ee(input logic f);
        @(negedge clk);
        ee_load_valid = 1'b1;
        ee_load_fundamental = f;
        @(negedge clk);
        ee_load_valid = 1'b0;
    endtask
    task automatic retry(input logic [1:0] exp);
        @(negedge clk);
        vif_type0_cfg = 1'b1;
        lif_type0_cfg = 1'b1;
        #10 chk({vif_cfg_retry, lif_cfg_retry}, exp);
        @(negedge clk);
        vif_type0_cfg = 1'b0;
        lif_type0_cfg = 1'b0;
    endtask
    initial forever #12.5 clk = ~clk;
    initial forever @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            num_errors++;
            stop_test();
        end
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        fres();
        u_host.rd(A, rv);
        chk(rv, 32'h0);
        retry(2'h3);
        u_host.wr(A, 32'hffff_ffff);
        u_host.rd(A, rv);
        chk(rv, 32'h0f00_003f);
        retry(2'h0);
        u_host.wr(12'ha34, 32'hffff_ffff);
        u_host.rd(12'ha34, rv);
        chk(rv, 32'h0);
        $display("register test done");
        for (int i = 0; i < 16; i++) begin
            u_host.wr(A, {5'h0, i[3], 21'h0, i[2:0], 2'h0});
            @(negedge clk);
            us_hot_reset = 1'b1;
            #10 chk({hot_reset_full, hot_reset_cfg, downstream_hot_reset, eeprom_reload, eeprom_skip_ntlink},
                i[2] ? 5'h0 : {~i[0], i[0], 1'b1, ~i[1], i[3] & (i[1:0] == 2'h0)});
            @(negedge clk);
            us_hot_reset = 1'b0;
        end
        u_host.rd(A, rv);
        chk(rv, 32'h0400_001c);
        ee(1'b0);
        u_host.rd(A, rv);
        chk(rv, 32'h0000_0004);
        ee(1'b1);
        u_host.rd(A, rv);
        chk(rv, 32'h0);
        // link-only load set, inhibit clear; sweep bits 4:2 against dl_down and nt link reset
        for (int i = 0; i < 8; i++) begin
            u_host.wr(A, {4'h0, 1'b1, 22'h0, i[2:0], 2'h0});
            @(negedge clk);
            us_dl_down = 1'b1;
            #10 chk({hot_reset_full, hot_reset_cfg, downstream_hot_reset, eeprom_reload, eeprom_ntlink_only},
                {~i[2], 1'b0, ~i[2], ~i[1], i[2:0] == 3'h0});
            @(negedge clk);
            us_dl_down = 1'b0;
            ntl_reset = 1'b1;
            #10 chk({downstream_hot_reset, eeprom_reload, eeprom_skip_ntlink, eeprom_ntlink_only},
                {3'h0, ~i[1]});
            @(negedge clk);
            ntl_reset = 1'b0;
        end
        $display("reset control test done");
        for (int p = 0; p < 4; p++) begin
            fres();
            u_host.wr(A, {30'h0, p[1:0]});
            @(negedge clk);
            fatal_external = 1'b1;
            tx_in_packet = 1'b1;
            #10 chk(tx_block, p > 1);
            @(negedge clk);
            fatal_external = 1'b0;
            chk({send_fatal_msg, log_header, internal_chip_reset, log_uncorr_status, tx_insert_edb,
                force_link_down, fatal_error_out_n, per_vswitch_fatal_error_out_n}, EXP[p]);
            repeat (5) @(negedge clk);
            chk({tx_block, force_link_down, fatal_error_out_n}, {p > 1, p == 3, p == 1});
            tx_in_packet = 1'b0;
        end
        fres();
        fatal_vs_sel = 2'h2;
        fatal_ecc = 1'b1;
        @(negedge clk);
        fatal_ecc = 1'b0;
        chk({send_fatal_int_msg, fatal_error_out_n, per_vswitch_fatal_error_out_n}, 4'h9);
        $display("fatal policy test done");
        eeprom_present = 1'b0;
        fres();
        u_host.rd(A, rv);
        chk(rv, 32'h0100_0000);
        is_upstream = 1'b0;
        fres();
        u_host.wr(A, 32'hffff_ffff);
        u_host.rd(A, rv);
        chk(rv, 32'h0);
        $display("strap test done");
        stop_test();
    end
endmodule
bind fer_top fer_top_props u_props (.clk, .rst_n, .is_upstream, .base_mode, .nt_present, .cfg_rd, .cfg_rdata,
    .tx_in_packet, .vif_type0_cfg, .lif_type0_cfg, .fatal_error_out_n, .log_header, .send_fatal_msg,
    .send_fatal_int_msg, .log_uncorr_status, .internal_chip_reset, .tx_block, .tx_insert_edb, .force_link_down,
    .vif_cfg_retry, .lif_cfg_retry);
`default_nettype wire

/* fer_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module fer_top_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // config and requests
    input wire logic        is_upstream,
    input wire logic        base_mode,
    input wire logic        nt_present,
    input wire logic        cfg_rd,
    input wire logic [31:0] cfg_rdata,
    input wire logic        tx_in_packet,
    input wire logic        vif_type0_cfg,
    input wire logic        lif_type0_cfg,
    // actions
    input wire logic        fatal_error_out_n,
    input wire logic        log_header,
    input wire logic        send_fatal_msg,
    input wire logic        send_fatal_int_msg,
    input wire logic        log_uncorr_status,
    input wire logic        internal_chip_reset,
    input wire logic        tx_block,
    input wire logic        tx_insert_edb,
    input wire logic        force_link_down,
    input wire logic        vif_cfg_retry,
    input wire logic        lif_cfg_retry
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence down_read;
        cfg_rd && !is_upstream;
    endsequence
    sequence fenced;
        !fatal_error_out_n && tx_block;
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    fence_hold_a: assert property (fenced |=> fenced) else $error("fence released");
    fatal_hold_a: assert property (!fatal_error_out_n |=> !fatal_error_out_n) else $error("fatal out rose");
    link_down_a: assert property (force_link_down |-> tx_block ##1 force_link_down) else $error("link down");
    report_msg_a: assert property (send_fatal_msg |-> log_header && !fatal_error_out_n && !tx_block)
        else $error("report order");
    ecc_out_a: assert property (send_fatal_int_msg |-> !fatal_error_out_n) else $error("ecc out");
    ireset_quiet_a: assert property (internal_chip_reset |-> base_mode && !send_fatal_msg && !tx_block)
        else $error("reset policy");
    block_quiet_a: assert property (log_uncorr_status |-> tx_block && !fatal_error_out_n && !send_fatal_msg)
        else $error("block policy");
    edb_cause_a: assert property (tx_insert_edb |-> tx_block && $past(tx_in_packet)) else $error("edb");
    vif_retry_a: assert property (vif_cfg_retry |-> vif_type0_cfg && base_mode && nt_present)
        else $error("vif retry");
    lif_retry_a: assert property (lif_cfg_retry |-> lif_type0_cfg && base_mode && nt_present)
        else $error("lif retry");
    down_zero_a: assert property (down_read |=> cfg_rdata == 32'h0) else $error("downstream read");
endmodule
`default_nettype wire
